// ==== core/adcsc_core.sv ====
// Purpose: Serial command decoder and frame builder of the ADC.
// Assumes: Link clock is sampled by i_ref_clk; data shifts out on rising
//          edges and is sampled on falling edges of the serial clock.
// Notes: Input checksum result comes from an outside engine.
`timescale 1ns/1ps
module adcsc_core (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire adcsc_pkg::adcsc_pins_t i_pins,
    input wire logic signed [adcsc_pkg::RAW_W-1:0] i_ch0_raw,
    input wire logic signed [adcsc_pkg::RAW_W-1:0] i_ch1_raw,
    input wire logic [1:0] i_data_ready,
    input wire logic i_crc_fail,
    input wire logic [15:0] i_out_crc,
    output logic o_dout,
    output logic o_standby,
    output logic o_locked,
    output logic o_crc_error,
    output logic o_regs_reset
);
    import adcsc_pkg::*;

    adcsc_pins_t pins_s;
    logic sclk_d, cs_d, sclk_rise, sclk_fall, cs_rise, cs_fall, in_frame;
    logic [4:0] bit_r;
    logic [7:0] word_r;
    logic [30:0] rx_r;
    logic [31:0] tx_r, tx_nxt, w32;
    logic [15:0] rx16;
    logic [5:0] wlast;
    logic [15:0] cmd_r;
    logic cmd_valid_r;
    logic [15:0] regs_r [ADDR_MODE:ADDR_LAST];
    logic [1:0] wl;
    logic [23:0] ch0_r, ch1_r;
    logic crc_err_r, reset_flag_r;
    logic [15:0] status_w, resp_r;
    logic multi_r, resp_stat_r;
    logic [5:0] rd_addr_r;
    logic [6:0] rd_cnt_r;
    logic [7:0] wr_cnt_r;
    logic [5:0] wr_addr;
    logic wr_en, word_end;
    adcsc_kind_t kind;

    // ---------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ---------------------------------------------------------------
    adcsc_sync #(.W(3)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_pins),
        .i_idle(3'h2),
        .o_sync(pins_s)
    );

    // Delayed copies of the synchronised pins give the edges.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sclk_d <= pins_s.sclk;
            cs_d <= pins_s.cs_n;
        end
    end

    assign in_frame = !pins_s.cs_n && !cs_d;
    assign sclk_rise = in_frame && pins_s.sclk && !sclk_d;
    assign sclk_fall = in_frame && !pins_s.sclk && sclk_d;
    assign cs_fall = !pins_s.cs_n && cs_d;
    assign cs_rise = pins_s.cs_n && !cs_d;

    // ---------------------------------------------------------------
    // Conversion codes
    // ---------------------------------------------------------------
    // Wider modulator results saturate into the 24-bit code range.
    function automatic logic [23:0] clip(input logic signed [RAW_W-1:0] v);
        if (v <= $signed({{(RAW_W-24){1'b1}}, CODE_MIN}))
            return CODE_MIN;
        else if (v >= $signed({{(RAW_W-24){1'b0}}, CODE_MAX}))
            return CODE_MAX;
        else
            return v[23:0];
    endfunction : clip

    // Codes pass straight through inside range, so zero maps to zero.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            ch0_r <= 24'h000000;
            ch1_r <= 24'h000000;
        end else begin
            ch0_r <= clip(i_ch0_raw);
            ch1_r <= clip(i_ch1_raw);
        end
    end

    // ---------------------------------------------------------------
    // Word framing
    // ---------------------------------------------------------------
    assign wl = regs_r[ADDR_MODE][WL_LSB+1:WL_LSB];
    assign wlast = (wl == WL_16) ? 6'd15 : (wl == WL_24) ? 6'd23 : 6'd31;
    assign w32 = {rx_r, pins_s.din};
    assign word_end = sclk_fall && ({1'b0, bit_r} == wlast);

    // Data bits sit at the top of each word; in 24- and 32-bit words the low end is padding.
    always_comb begin
        case (wl)
            WL_16: rx16 = w32[15:0];
            WL_24: rx16 = w32[23:8];
            default: rx16 = w32[31:16];
        endcase
    end

    // Bit and word counters restart at every chip select fall.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n || cs_fall) begin
            bit_r <= 5'h00;
            word_r <= 8'h00;
            rx_r <= '0;
        end else if (sclk_fall) begin
            rx_r <= w32[30:0];
            bit_r <= word_end ? 5'h00 : bit_r + 5'h01;
            if (word_end && word_r != 8'hff)
                word_r <= word_r + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // Transmit word selection
    // ---------------------------------------------------------------
    function automatic logic [31:0] pad16(input logic [15:0] d);
        return {d, 16'h0000};
    endfunction : pad16

    function automatic logic [31:0] pad24(input logic [23:0] d, input logic [1:0] m);
        case (m)
            WL_16: return {d[23:8], 16'h0000};
            WL_24, WL_32Z: return {d, 8'h00};
            default: return {{8{d[23]}}, d};
        endcase
    endfunction : pad24

    function automatic logic [15:0] reg_read(input logic [5:0] a, input logic [15:0] st);
        if (a == ADDR_ID)
            return ID_VALUE;
        else if (a == ADDR_STATUS)
            return st;
        else if (a <= ADDR_LAST)
            return regs_r[a];
        else
            return 16'h0000;
    endfunction : reg_read

    assign status_w = {o_locked, 2'h0, crc_err_r, 1'h0, reset_flag_r, wl, 6'h00, i_data_ready};

    // Multi-register answers replace conversion words with register words.
    always_comb begin
        tx_nxt = 32'h00000000;
        if (word_r == 8'h00)
            tx_nxt = pad16(resp_stat_r ? status_w : resp_r);
        else if (multi_r) begin
            if (word_r <= {1'b0, rd_cnt_r} + 8'h01)
                tx_nxt = pad16(reg_read(rd_addr_r + word_r[5:0] - 6'h01, status_w));
            else if (word_r == {1'b0, rd_cnt_r} + 8'h02)
                tx_nxt = pad16(i_out_crc);
        end else if (word_r == 8'h01)
            tx_nxt = pad24(ch0_r, wl);
        else if (word_r == 8'h02)
            tx_nxt = pad24(ch1_r, wl);
        else if (word_r == 8'h03)
            tx_nxt = pad16(i_out_crc);
    end

    // A new word is loaded on the first rising edge of each word.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n || cs_fall) begin
            tx_r <= 32'h00000000;
            o_dout <= 1'b0;
        end else if (sclk_rise) begin
            if (bit_r == 5'h00) begin
                o_dout <= tx_nxt[31];
                tx_r <= {tx_nxt[30:0], 1'b0};
            end else begin
                o_dout <= tx_r[31];
                tx_r <= {tx_r[30:0], 1'b0};
            end
        end
    end

    // ---------------------------------------------------------------
    // Command capture and decode
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n || cs_fall) begin
            cmd_r <= CMD_NOP;
            cmd_valid_r <= 1'b0;
        end else if (word_end && word_r == 8'h00) begin
            cmd_r <= rx16;
            cmd_valid_r <= 1'b1;
        end
    end

    // Anything not matching a known encoding falls back to no-operation.
    always_comb begin
        case (cmd_r)
            CMD_RESET: kind = K_RESET;
            CMD_STANDBY: kind = K_STANDBY;
            CMD_WAKEUP: kind = K_WAKEUP;
            CMD_LOCK: kind = K_LOCK;
            CMD_UNLOCK: kind = K_UNLOCK;
            default: begin
                if (cmd_r[15:13] == OP_READ)
                    kind = K_READ;
                else if (cmd_r[15:13] == OP_WRITE)
                    kind = K_WRITE;
                else
                    kind = K_NOP;
            end
        endcase
        if (!cmd_valid_r)
            kind = K_NOP;
    end

    // ---------------------------------------------------------------
    // Register writes during the frame
    // ---------------------------------------------------------------
    // Writes land as words arrive, so a later checksum failure cannot undo them.
    assign wr_addr = cmd_r[12:7] + word_r[5:0] - 6'h01;
    assign wr_en = word_end && kind == K_WRITE && !o_locked && word_r != 8'h00
        && word_r <= {1'b0, cmd_r[6:0]} + 8'h01;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n || (cs_rise && kind == K_RESET && word_r >= FULL_WORDS && !i_crc_fail
            && !o_locked)) begin
            for (int i = ADDR_MODE; i <= ADDR_LAST; i++)
                regs_r[i] <= 16'h0000;
            regs_r[ADDR_MODE] <= MODE_RESET;
            regs_r[ADDR_CLOCK] <= CLOCK_RESET;
        end else if (wr_en && wr_addr >= ADDR_MODE && wr_addr <= ADDR_LAST) begin
            regs_r[wr_addr] <= rx16;
        end
    end

    // Only writable addresses count toward the written total.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n || cs_fall)
            wr_cnt_r <= 8'h00;
        else if (wr_en && wr_addr >= ADDR_MODE && wr_addr <= ADDR_LAST)
            wr_cnt_r <= wr_cnt_r + 8'h01;
    end

    // ---------------------------------------------------------------
    // End-of-frame execution and next response
    // ---------------------------------------------------------------
    // Lock gating reduces a command to no-operation; checksum failure does too, except for writes that have already landed.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            resp_r <= CMD_NOP;
            resp_stat_r <= 1'b1;
            multi_r <= 1'b0;
            rd_addr_r <= 6'h00;
            rd_cnt_r <= 7'h00;
            o_standby <= 1'b0;
            o_locked <= 1'b0;
            o_regs_reset <= 1'b0;
        end else begin
            o_regs_reset <= 1'b0;
            if (cs_rise) begin
                resp_stat_r <= 1'b0;
                multi_r <= 1'b0;
                resp_r <= cmd_r;
                if (i_crc_fail) begin
                    resp_stat_r <= 1'b1;
                end else if (o_locked && kind != K_READ && kind != K_UNLOCK) begin
                    resp_stat_r <= 1'b1;
                end else begin
                    case (kind)
                        K_RESET: begin
                            if (word_r >= FULL_WORDS) begin
                                resp_r <= RESP_RESET_OK;
                                o_locked <= 1'b0;
                                o_standby <= 1'b0;
                                o_regs_reset <= 1'b1;
                            end else
                                resp_r <= RESP_RESET_CUT;
                        end
                        K_STANDBY: o_standby <= 1'b1;
                        K_WAKEUP: o_standby <= 1'b0;
                        K_LOCK: o_locked <= 1'b1;
                        K_UNLOCK: o_locked <= 1'b0;
                        K_READ: begin
                            rd_addr_r <= cmd_r[12:7];
                            rd_cnt_r <= cmd_r[6:0];
                            if (cmd_r[6:0] == 7'h00)
                                resp_r <= reg_read(cmd_r[12:7], status_w);
                            else begin
                                multi_r <= 1'b1;
                                resp_r <= {ACK_READ, cmd_r[12:0]};
                            end
                        end
                        K_WRITE: resp_r <= {ACK_WRITE, cmd_r[12:7], wr_cnt_r[6:0] - 7'h01};
                        default: resp_stat_r <= 1'b1;
                    endcase
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Status flags
    // ---------------------------------------------------------------
    // Flags clear once the status word is loaded and its first bit goes out; a new event in that cycle wins.
    logic stat_out;
    assign stat_out = sclk_rise && word_r == 8'h00 && bit_r == 5'h00 && resp_stat_r;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            crc_err_r <= 1'b0;
            reset_flag_r <= 1'b1;
        end else begin
            if (cs_rise && i_crc_fail)
                crc_err_r <= 1'b1;
            else if (stat_out)
                crc_err_r <= 1'b0;
            if (o_regs_reset)
                reset_flag_r <= 1'b1;
            else if (stat_out)
                reset_flag_r <= 1'b0;
        end
    end

    assign o_crc_error = crc_err_r;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    chk_clip_low: assert property (i_ch1_raw <= -26'sh800000 |=> ch1_r == CODE_MIN)
        else $error("Channel 1 did not clip to the lowest code.");
    chk_clip_high: assert property (i_ch0_raw > 26'sh7fffff |=> ch0_r == CODE_MAX)
        else $error("Channel 0 did not clip to the highest code.");
    chk_zero_code: assert property (i_ch1_raw == '0 |=> ch1_r == 24'h000000)
        else $error("Zero input did not give the zero code.");
    chk_reset_ack: assert property (cs_rise && kind == K_RESET && word_r >= FULL_WORDS
        && !i_crc_fail && !o_locked |=> resp_r == RESP_RESET_OK && o_regs_reset && !o_locked)
        else $error("Full reset frame was not acknowledged.");
    chk_reset_cut: assert property (cs_rise && kind == K_RESET && word_r < FULL_WORDS
        && !i_crc_fail && !o_locked |=> resp_r == RESP_RESET_CUT && !o_regs_reset)
        else $error("Short reset frame was not refused.");
    chk_lock_hold: assert property (o_locked && cs_rise
        && (kind == K_STANDBY || kind == K_WAKEUP) |=> $stable(o_standby))
        else $error("Locked interface obeyed a standby word.");
    chk_crc_noop: assert property (cs_rise && i_crc_fail |=> resp_stat_r && crc_err_r && !multi_r)
        else $error("Checksum failure did not give the no-operation answer.");
    chk_echo_word: assert property (cs_rise && !i_crc_fail && !o_locked
        && (kind == K_STANDBY || kind == K_LOCK) |=> resp_r == $past(cmd_r) && !resp_stat_r)
        else $error("Mode command was not echoed.");
    chk_standby_at: assert property (cs_rise && kind == K_WAKEUP && !i_crc_fail && !o_locked
        |=> !o_standby)
        else $error("Wakeup did not leave standby.");
    chk_write_pend: assert property (cs_rise && kind == K_WRITE && !i_crc_fail && !o_locked
        |=> resp_r[15:13] == ACK_WRITE && resp_r[12:7] == $past(cmd_r[12:7]))
        else $error("Write answer has the wrong form.");
endmodule : adcsc_core

// ==== common/adcsc_pkg.sv ====
// Purpose: Constants and types for the ADC serial command decoder.
// Assumes: 10 MHz core clock, serial link sampled in that domain.
// Notes: Command, response and register words hold 16 data bits.
package adcsc_pkg;
    // ---------------------------------------------------------------
    // Command words and fixed responses.
    // ---------------------------------------------------------------
    localparam logic [15:0] CMD_NOP = 16'h0000;
    localparam logic [15:0] CMD_RESET = 16'h0011;
    localparam logic [15:0] CMD_STANDBY = 16'h0022;
    localparam logic [15:0] CMD_WAKEUP = 16'h0033;
    localparam logic [15:0] CMD_LOCK = 16'h0555;
    localparam logic [15:0] CMD_UNLOCK = 16'h0655;
    localparam logic [2:0] OP_READ = 3'h5;
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [2:0] ACK_READ = 3'h7;
    localparam logic [2:0] ACK_WRITE = 3'h2;
    localparam logic [15:0] RESP_RESET_OK = 16'hff42;
    localparam logic [15:0] RESP_RESET_CUT = 16'h0011;
    // ---------------------------------------------------------------
    // Register map and layout.
    // ---------------------------------------------------------------
    localparam logic [5:0] ADDR_ID = 6'h00;
    localparam logic [5:0] ADDR_STATUS = 6'h01;
    localparam logic [5:0] ADDR_MODE = 6'h02;
    localparam logic [5:0] ADDR_CLOCK = 6'h03;
    localparam logic [5:0] ADDR_LAST = 6'h07;
    localparam logic [15:0] ID_VALUE = 16'h1234; // Arbitrary identification value.
    localparam logic [15:0] MODE_RESET = 16'h0510;
    localparam logic [15:0] CLOCK_RESET = 16'h038e;
    localparam int WL_LSB = 8;
    localparam int ST_LOCK = 15;
    localparam int ST_CRC = 12;
    localparam int ST_RESET = 10;
    localparam logic [1:0] WL_16 = 2'h0;
    localparam logic [1:0] WL_24 = 2'h1;
    localparam logic [1:0] WL_32Z = 2'h2;
    // ---------------------------------------------------------------
    // Conversion codes and frame shape.
    // ---------------------------------------------------------------
    localparam int RAW_W = 26;
    localparam logic [23:0] CODE_MIN = 24'h800000;
    localparam logic [23:0] CODE_MAX = 24'h7fffff;
    localparam logic [7:0] FULL_WORDS = 8'h04;
    localparam int SYNC_STAGES = 2;
    // ---------------------------------------------------------------
    // Types.
    // ---------------------------------------------------------------
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } adcsc_pins_t;
    typedef enum {
        K_NOP, K_RESET, K_STANDBY, K_WAKEUP, K_LOCK, K_UNLOCK, K_READ, K_WRITE
    } adcsc_kind_t;
endpackage : adcsc_pkg

// ==== core/adcsc_sync.sv ====
// Purpose: Two-stage synchroniser for the serial link pins.
// Assumes: Inputs are asynchronous to i_ref_clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module adcsc_sync #(
    parameter int W = 3
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_async,
    input wire logic [W-1:0] i_idle,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    // --------------------------------------------------------------
    // Stages
    // --------------------------------------------------------------
    // The first stage feeds only the second, to keep metastability contained.
    // Reset loads the idle pattern so no false pin edge follows reset.
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            meta_r <= i_idle;
            o_sync <= i_idle;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule : adcsc_sync

// ==== verif/adcsc_host_model.sv ====
// Purpose: Host side of the serial link, one frame per call of xfer.
// Assumes: 24-bit words; serial clock period of eight core clocks.
// Notes: Words to send sit in tx, words received land in rx.
`timescale 1ns/1ps
module adcsc_host_model (
    input wire logic i_ref_clk,
    input wire logic i_dout,
    output adcsc_pkg::adcsc_pins_t o_pins
);
    import adcsc_pkg::*;
    logic [23:0] tx [8];
    logic [23:0] rx [8];
    initial o_pins = 3'b010;
    // Idle data line toggles so a stale level is never mistaken for data.
    always @(posedge i_ref_clk) if (o_pins.cs_n) o_pins.din <= ~o_pins.din;
    // Data changes on the rising serial edge and is read just before the next one.
    task automatic xfer(input int n);
        @(posedge i_ref_clk) o_pins.cs_n <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        for (int w = 0; w < n; w++) begin
            for (int b = 23; b >= 0; b--) begin
                o_pins.sclk <= 1'b1;
                o_pins.din <= tx[w][b];
                repeat (4) @(posedge i_ref_clk);
                o_pins.sclk <= 1'b0;
                repeat (4) @(posedge i_ref_clk);
                rx[w][b] = i_dout;
            end
        end
        o_pins.cs_n <= 1'b1;
        repeat (8) @(posedge i_ref_clk);
    endtask : xfer
endmodule : adcsc_host_model

// ==== verif/adc_spi_command_decoder_bench.sv ====
// Purpose: Self-checking bench for the serial command decoder.
// Assumes: Default 24-bit words; ready bits held at 01.
// Notes: Each task leaves a status answer pending for the next one.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module adc_spi_command_decoder_bench;
    import adcsc_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic signed [RAW_W-1:0] ch0 = 26'sh1000000;
    logic signed [RAW_W-1:0] ch1 = -26'sh2000000;
    logic crc_fail = 1'b0;
    logic [15:0] out_crc = 16'hc3a5;
    logic dout, standby, locked, crc_err, regs_reset;
    adcsc_pins_t pins;
    int failures = 0;
    int n_checks = 0;
    int n_rst = 0;
    initial forever #50 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) if (regs_reset === 1'b1) n_rst <= n_rst + 1;
    adcsc_host_model host_u (.i_ref_clk(i_ref_clk), .i_dout(dout), .o_pins(pins));
    adcsc_core dut_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_pins(pins),
        .i_ch0_raw(ch0), .i_ch1_raw(ch1), .i_data_ready(2'h1), .i_crc_fail(crc_fail),
        .i_out_crc(out_crc), .o_dout(dout), .o_standby(standby), .o_locked(locked),
        .o_crc_error(crc_err), .o_regs_reset(regs_reset));
    // -------------------------------------------------------------------
    // Helpers.
    // -------------------------------------------------------------------
    task automatic frame(input logic [15:0] cmd, input int n);
        host_u.tx[0] = {cmd, 8'h00};
        host_u.xfer(n);
        for (int i = 0; i < 8; i++) host_u.tx[i] = 24'h000000;
    endtask : frame
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    // -------------------------------------------------------------------
    // Scenarios.
    // -------------------------------------------------------------------
    task automatic t_nop();
        frame(CMD_NOP, 4);
        `CHK(host_u.rx[0], 24'h050100)
        `CHK(host_u.rx[1], 24'h7fffff)
        `CHK(host_u.rx[2], 24'h800000)
        `CHK(host_u.rx[3], {out_crc, 8'h00})
        @(posedge i_ref_clk) ch0 <= 26'sh0000001;
        ch1 <= 26'sh0000000;
        frame(16'h0044, 4);
        `CHK(host_u.rx[0], 24'h010100)
        `CHK(host_u.rx[1], 24'h000001)
        `CHK(host_u.rx[2], 24'h000000)
        frame(CMD_NOP, 4);
        `CHK(host_u.rx[0], 24'h010100)
        `CHK({standby, locked}, 2'b00)
        $display("t_nop done");
    endtask : t_nop
    task automatic t_modes();
        frame(CMD_STANDBY, 4);
        `CHK(standby, 1'b1)
        frame(CMD_LOCK, 4);
        `CHK(host_u.rx[0], 24'h002200)
        `CHK(locked, 1'b1)
        frame(CMD_WAKEUP, 4);
        `CHK(host_u.rx[0], 24'h055500)
        `CHK(host_u.rx[1], 24'h000001)
        `CHK(standby, 1'b1)
        frame(CMD_UNLOCK, 4);
        `CHK(host_u.rx[0], 24'h810100)
        `CHK(locked, 1'b0)
        frame(CMD_WAKEUP, 4);
        `CHK(host_u.rx[0], 24'h065500)
        `CHK(standby, 1'b0)
        frame(CMD_NOP, 4);
        `CHK(host_u.rx[0], 24'h003300)
        $display("t_modes done");
    endtask : t_modes
    task automatic t_regs();
        host_u.tx[1] = 24'habcd00;
        host_u.tx[2] = 24'h5a5a00;
        frame({OP_WRITE, 6'h04, 7'h01}, 4);
        frame({OP_READ, 6'h04, 7'h01}, 4);
        `CHK(host_u.rx[0], {ACK_WRITE, 6'h04, 7'h01, 8'h00})
        frame(CMD_NOP, 4);
        `CHK(host_u.rx[0], {ACK_READ, 6'h04, 7'h01, 8'h00})
        `CHK(host_u.rx[1], 24'habcd00)
        `CHK(host_u.rx[2], 24'h5a5a00)
        `CHK(host_u.rx[3], {out_crc, 8'h00})
        frame({OP_READ, 6'h03, 7'h00}, 4);
        frame(CMD_NOP, 4);
        `CHK(host_u.rx[0], {CLOCK_RESET, 8'h00})
        $display("t_regs done");
    endtask : t_regs
    // Register 4 holds abcdh from t_regs, so reading zero proves the reset.
    task automatic t_reset();
        @(posedge i_ref_clk) crc_fail <= 1'b1;
        frame(CMD_STANDBY, 4);
        `CHK({standby, crc_err}, 2'b01)
        @(posedge i_ref_clk) crc_fail <= 1'b0;
        frame(CMD_RESET, 2);
        `CHK(host_u.rx[0], 24'h110100)
        frame(CMD_NOP, 4);
        `CHK(host_u.rx[0], 24'h001100)
        `CHK(n_rst, 0)
        frame(CMD_RESET, 4);
        `CHK(n_rst, 1)
        repeat (20) @(posedge i_ref_clk);
        frame({OP_READ, 6'h04, 7'h00}, 4);
        `CHK(host_u.rx[0], 24'hff4200)
        frame(CMD_LOCK, 4);
        `CHK(host_u.rx[0], 24'h000000)
        `CHK(locked, 1'b1)
        // A mid-run pin reset while locked must release the lock.
        @(posedge i_ref_clk) i_reset_n <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        `CHK(locked, 1'b0)
        frame(CMD_NOP, 4);
        `CHK(host_u.rx[0], 24'h050100)
        $display("t_reset done");
    endtask : t_reset
    // -------------------------------------------------------------------
    // Main sequence and watchdog.
    // -------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        t_nop();
        t_modes();
        t_regs();
        t_reset();
        tally_and_finish();
    end
    // A hang counts as a mismatch and ends the run through the same report.
    initial begin
        repeat (60000) @(posedge i_ref_clk);
        failures++;
        tally_and_finish();
    end
endmodule : adc_spi_command_decoder_bench
